// >>> rtl/ibcgd_pkg.sv
package ibcgd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_LEN_CTRL = 6'h12;
  localparam logic [5:0] IDX_TX_PAT = 6'h13;
  localparam logic [5:0] IDX_RX_UP_PAT = 6'h14;
  localparam logic [5:0] IDX_RX_DN_PAT = 6'h15;
  localparam logic [5:0] IDX_CTRL3 = 6'h16;
  localparam logic [5:0] IDX_STATUS1 = 6'h17;
  localparam logic [5:0] IDX_INT_STAT = 6'h18;
  localparam logic [5:0] IDX_INT_MASK = 6'h19;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TXLEN_HI = 7;
  localparam int TXLEN_LO = 6;
  localparam int UPLEN_MSB = 5;
  localparam int UPLEN_LSB = 3;
  localparam int DNLEN_MSB = 2;
  localparam int DNLEN_LSB = 0;
  localparam int TX_EN_BIT = 1;
  localparam int LOOPUP_BIT = 7;
  localparam int LOOPDN_BIT = 6;
  localparam logic [7:0] STAT_MASK = 8'hC0;
  localparam logic [7:0] CTRL3_MASK = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] LEN_CTRL_RST = 8'h00;
  localparam logic [7:0] PAT_RST = 8'h00;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] INT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int INTEG_TIME_MS = 48;
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int INTEG_CYC = INTEG_TIME_MS * CLK_FREQ_KHZ;
  localparam int INTEG_CNT_W = 21;

  typedef enum logic [1:0] {
    TXLEN_5,
    TXLEN_6,
    TXLEN_7,
    TXLEN_8
  } ibcgd_txlen_type;

endpackage : ibcgd_pkg

// >>> rtl/ibcgd_txgen.sv
`timescale 1ns/1ps
module ibcgd_txgen
  import ibcgd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings
  input wire logic enable,
  input wire logic [7:0] pattern,
  input wire logic [1:0] len_sel,
  // Formatter side
  input wire logic bit_req,
  input wire logic fbit_slot,
  input wire logic fbit_value,
  input wire logic fbit_insert_en,
  input wire logic data_in,
  // Line side
  output logic data_out,
  output logic active
);

  typedef struct packed {
    logic [2:0] phase;
    logic dout;
    logic act;
  } ibcgd_tx_type;

  ibcgd_tx_type s_reg;
  ibcgd_tx_type s_next;
  logic [2:0] last_phase;
  logic pat_bit;

  always_comb begin
    unique case (ibcgd_txlen_type'(len_sel))
      TXLEN_5: last_phase = 3'h4;
      TXLEN_6: last_phase = 3'h5;
      TXLEN_7: last_phase = 3'h6;
      TXLEN_8: last_phase = 3'h7;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.act = enable;
    if (bit_req) begin
      if (enable) begin
        // Pattern keeps advancing under the F bit, as the far end expects
        if (fbit_slot && fbit_insert_en) begin
          s_next.dout = fbit_value;
        end else begin
          s_next.dout = pattern[3'h7 - s_reg.phase];
        end
        if (s_reg.phase >= last_phase) begin
          s_next.phase = 3'h0;
        end else begin
          s_next.phase = s_reg.phase + 3'h1;
        end
      end else begin
        s_next.dout = data_in;
        s_next.phase = 3'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data_out = s_reg.dout;
  assign active = s_reg.act;
  assign pat_bit = pattern[3'h7 - s_reg.phase];

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fbit_overwrite: assert property (
    bit_req && enable && fbit_slot && fbit_insert_en
      |=> data_out == $past(fbit_value))
    else $error("F bit not placed");
  a_pattern_bit: assert property (
    bit_req && enable && !(fbit_slot && fbit_insert_en)
      |=> data_out == $past(pat_bit))
    else $error("Wrong pattern bit");
  a_five_bit_wrap: assert property (
    bit_req && enable && len_sel == 2'h0 && s_reg.phase == 3'h4
      |=> s_reg.phase == 3'h0)
    else $error("Five bit length not wrapping");
  a_stop_passthru: assert property (
    bit_req && !enable |=> data_out == $past(data_in) && !active)
    else $error("Pattern sent while disabled");

endmodule : ibcgd_txgen

// >>> rtl/ibcgd_det.sv
`timescale 1ns/1ps
module ibcgd_det
  import ibcgd_pkg::*;
#(
  parameter int INTEG_CYCLES = INTEG_CYC
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings
  input wire logic [7:0] pattern,
  input wire logic [2:0] len_m1,
  // Received stream
  input wire logic bit_valid,
  input wire logic bit_in,
  // Result
  output logic detected
);

  localparam logic [INTEG_CNT_W-1:0] WIN_END =
    INTEG_CNT_W'(INTEG_CYCLES - 1);

  typedef struct packed {
    logic [7:0] hist;
    logic [INTEG_CNT_W-1:0] timer;
    logic [INTEG_CNT_W-1:0] bits;
    logic [INTEG_CNT_W-1:0] miss;
    logic det;
  } ibcgd_det_type;

  ibcgd_det_type s_reg;
  ibcgd_det_type s_next;

  // Last len bits equal some rotation of the pattern; framing-blind
  function automatic logic rot_match(logic [7:0] h, logic [7:0] p,
                                     logic [2:0] lm1);
    logic any;
    logic ok;
    int len;
    int idx;
    any = 1'b0;
    len = int'(lm1) + 1;
    for (int r = 0; r < 8; r++) begin
      ok = (r < len);
      for (int j = 0; j < 8; j++) begin
        if (j < len) begin
          idx = r + j;
          if (idx >= len) begin
            idx = idx - len;
          end
          if (h[len - 1 - j] != p[7 - idx]) begin
            ok = 1'b0;
          end
        end
      end
      any = any | ok;
    end
    return any;
  endfunction : rot_match

  always_comb begin
    s_next = s_reg;
    if (bit_valid) begin
      s_next.hist = {s_reg.hist[6:0], bit_in};
      if (s_reg.bits != '1) begin
        s_next.bits = s_reg.bits + 1'b1;
      end
      if (!rot_match(s_next.hist, pattern, len_m1) && s_reg.miss != '1) begin
        s_next.miss = s_reg.miss + 1'b1;
      end
    end
    if (s_reg.timer == WIN_END) begin
      // One miss in four tolerates 1e-2 errors times an 8-bit smear
      s_next.det = (s_reg.bits != '0) &&
        ({s_reg.miss, 2'b00} < {2'b00, s_reg.bits});
      s_next.timer = '0;
      s_next.bits = '0;
      s_next.miss = '0;
    end else begin
      s_next.timer = s_reg.timer + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign detected = s_reg.det;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_flag_holds: assert property (
    s_reg.timer != WIN_END |=> detected == $past(detected))
    else $error("Flag moved inside window");
  a_clean_window: assert property (
    s_reg.timer == WIN_END && s_reg.bits != '0 && s_reg.miss == '0
      |=> detected)
    else $error("Clean window not detected");
  c_detect_rise: cover property (!detected ##1 detected);

endmodule : ibcgd_det

// >>> rtl/ibcgd_top.sv
`timescale 1ns/1ps
module ibcgd_top
  import ibcgd_pkg::*;
#(
  parameter int INTEG_CYCLES = INTEG_CYC
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Transmit formatter side
  input wire logic tx_bit_req,
  input wire logic tx_fbit_slot,
  input wire logic tx_fbit_value,
  input wire logic tx_fbit_insert_en,
  input wire logic tx_data_in,
  output logic tx_data_out,
  output logic tx_code_active,
  // Receive framer side
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // Status
  output logic loopup_detected_flag,
  output logic loopdown_detected_flag,
  output logic irq
);

  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] len_ctrl;
    logic [7:0] tx_pat;
    logic [7:0] up_pat;
    logic [7:0] dn_pat;
    logic [7:0] ctrl3;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
    logic up_prev;
    logic dn_prev;
  } ibcgd_regs_type;

  localparam ibcgd_regs_type REGS_RST = '{
    aw_full: 1'b0, aw_addr: 8'h00, w_full: 1'b0, w_data: 8'h00,
    w_strb0: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
    rdata: 8'h00, rresp: RESP_OKAY, len_ctrl: LEN_CTRL_RST,
    tx_pat: PAT_RST, up_pat: PAT_RST, dn_pat: PAT_RST,
    ctrl3: CTRL3_RST, int_stat: INT_RST, int_mask: INT_RST,
    up_prev: 1'b0, dn_prev: 1'b0};

  ibcgd_regs_type s_reg;
  ibcgd_regs_type s_next;
  logic det_up;
  logic det_dn;
  logic [7:0] status_one;
  logic [7:0] events;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath blocks

  ibcgd_txgen u_txgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(s_reg.ctrl3[TX_EN_BIT]),
    .pattern(s_reg.tx_pat),
    .len_sel(s_reg.len_ctrl[TXLEN_HI:TXLEN_LO]),
    .bit_req(tx_bit_req),
    .fbit_slot(tx_fbit_slot),
    .fbit_value(tx_fbit_value),
    .fbit_insert_en(tx_fbit_insert_en),
    .data_in(tx_data_in),
    .data_out(tx_data_out),
    .active(tx_code_active)
  );

  // Two detectors see the same stream, each with its own settings
  ibcgd_det #(.INTEG_CYCLES(INTEG_CYCLES)) u_det_up (
    .aclk(aclk),
    .aresetn(aresetn),
    .pattern(s_reg.up_pat),
    .len_m1(s_reg.len_ctrl[UPLEN_MSB:UPLEN_LSB]),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .detected(det_up)
  );

  ibcgd_det #(.INTEG_CYCLES(INTEG_CYCLES)) u_det_dn (
    .aclk(aclk),
    .aresetn(aresetn),
    .pattern(s_reg.dn_pat),
    .len_m1(s_reg.len_ctrl[DNLEN_MSB:DNLEN_LSB]),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .detected(det_dn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave

  always_comb begin
    status_one = 8'h00;
    status_one[LOOPUP_BIT] = det_up;
    status_one[LOOPDN_BIT] = det_dn;
  end

  always_comb begin
    s_next = s_reg;
    wr_idx = s_reg.aw_addr[7:2];
    rd_idx = araddr[7:2];
    events = 8'h00;
    events[LOOPUP_BIT] = det_up & ~s_reg.up_prev;
    events[LOOPDN_BIT] = det_dn & ~s_reg.dn_prev;
    s_next.up_prev = det_up;
    s_next.dn_prev = det_dn;
    if (awvalid && awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata[7:0];
      s_next.w_strb0 = wstrb[0];
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (wr_idx)
        IDX_LEN_CTRL: begin
          if (s_reg.w_strb0) s_next.len_ctrl = s_reg.w_data;
        end
        IDX_TX_PAT: begin
          if (s_reg.w_strb0) s_next.tx_pat = s_reg.w_data;
        end
        IDX_RX_UP_PAT: begin
          if (s_reg.w_strb0) s_next.up_pat = s_reg.w_data;
        end
        IDX_RX_DN_PAT: begin
          if (s_reg.w_strb0) s_next.dn_pat = s_reg.w_data;
        end
        IDX_CTRL3: begin
          if (s_reg.w_strb0) s_next.ctrl3 = s_reg.w_data & CTRL3_MASK;
        end
        IDX_STATUS1: begin
          s_next.bresp = RESP_OKAY;
        end
        IDX_INT_STAT: begin
          if (s_reg.w_strb0) s_next.int_stat = s_reg.int_stat & ~s_reg.w_data;
        end
        IDX_INT_MASK: begin
          if (s_reg.w_strb0) s_next.int_mask = s_reg.w_data & STAT_MASK;
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    // Applied after the clear so a same-cycle event is never lost
    s_next.int_stat = (s_next.int_stat | events) & STAT_MASK;
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      case (rd_idx)
        IDX_LEN_CTRL: s_next.rdata = s_reg.len_ctrl;
        IDX_TX_PAT: s_next.rdata = s_reg.tx_pat;
        IDX_RX_UP_PAT: s_next.rdata = s_reg.up_pat;
        IDX_RX_DN_PAT: s_next.rdata = s_reg.dn_pat;
        IDX_CTRL3: s_next.rdata = s_reg.ctrl3;
        IDX_STATUS1: s_next.rdata = status_one;
        IDX_INT_STAT: s_next.rdata = s_reg.int_stat;
        IDX_INT_MASK: s_next.rdata = s_reg.int_mask;
        default: begin
          s_next.rdata = 8'h00;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= REGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // One write and one read in flight; no overlap with a pending answer
  assign awready = !s_reg.aw_full && !s_reg.bvalid;
  assign wready = !s_reg.w_full && !s_reg.bvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rresp = s_reg.rresp;
  assign rdata = {24'h000000, s_reg.rdata};
  assign loopup_detected_flag = det_up;
  assign loopdown_detected_flag = det_dn;
  assign irq = |(s_reg.int_stat & s_reg.int_mask);

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    s_reg.aw_full && s_reg.w_full && !s_reg.bvalid |=> bvalid)
    else $error("Write not answered");
  a_len_ctrl_write: assert property (
    s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && s_reg.w_strb0 &&
      wr_idx == IDX_LEN_CTRL |=> s_reg.len_ctrl == $past(s_reg.w_data))
    else $error("Length control not stored");
  a_status_read: assert property (
    arvalid && arready && rd_idx == IDX_STATUS1
      |=> rdata[LOOPUP_BIT] == $past(det_up) &&
          rdata[LOOPDN_BIT] == $past(det_dn))
    else $error("Status read mismatch");
  // Software may clear the bit right after, so only one cycle is certain
  a_event_sticky: assert property (
    $rose(det_up) |=> s_reg.int_stat[LOOPUP_BIT])
    else $error("Loop-up event not latched");

  c_up_irq: cover property ($rose(det_up) ##1 irq);
  c_down_seen: cover property ($rose(det_dn));
  c_tx_fbit: cover property (tx_code_active && tx_bit_req && tx_fbit_slot);

endmodule : ibcgd_top

// >>> verif/ibcgd_far_end.sv
`timescale 1ns/1ps
module ibcgd_far_end (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench settings
  input wire logic tx_go,
  input wire logic rx_on,
  input wire logic rx_framed,
  input wire logic rx_errs,
  input wire logic [7:0] rx_pat,
  input wire logic [3:0] rx_len,
  // Line slots
  output logic tx_bit_req,
  output logic tx_fbit_slot,
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic [1:0] div_reg;
  logic [7:0] tx_cnt_reg;
  logic [7:0] rx_cnt_reg;
  logic [6:0] err_cnt_reg;
  logic [3:0] ph_reg;
  //////////////////////////////////////////////////////////////////////////
  // F slot once in 193 transmit slots
  assign tx_fbit_slot = (tx_cnt_reg == 8'hC0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 2'h0;
      tx_cnt_reg <= 8'h00;
      rx_cnt_reg <= 8'h00;
      err_cnt_reg <= 7'h00;
      ph_reg <= 4'h0;
      tx_bit_req <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      tx_bit_req <= tx_go && (div_reg == 2'h0);
      rx_bit_valid <= (div_reg == 2'h2);
      if (tx_go && div_reg == 2'h0) begin
        tx_cnt_reg <= tx_fbit_slot ? 8'h00 : tx_cnt_reg + 8'h01;
      end
      if (div_reg == 2'h2) begin
        rx_cnt_reg <= (rx_cnt_reg == 8'hC0) ? 8'h00 : rx_cnt_reg + 8'h01;
        err_cnt_reg <= (err_cnt_reg == 7'h63) ? 7'h00 : err_cnt_reg + 7'h01;
        if (!rx_on) begin
          // Idle line toggles so a stale bit never looks like a code
          rx_bit <= ~rx_bit;
        end else if (rx_framed && rx_cnt_reg == 8'hC0) begin
          rx_bit <= 1'b1;
        end else begin
          // One flipped bit per hundred when errors are on
          rx_bit <= rx_pat[3'h7 - ph_reg[2:0]] ^ (rx_errs && err_cnt_reg == 7'h00);
          ph_reg <= (ph_reg == rx_len - 4'h1) ? 4'h0 : ph_reg + 4'h1;
        end
      end
    end
  end
endmodule : ibcgd_far_end

// >>> verif/test_ibcgd_top.sv
`timescale 1ns/1ps
module test_ibcgd_top
  import ibcgd_pkg::*;
;
  // Short window keeps the run small
  localparam int WIN = 2000;
  localparam int SETTLE = 2 * WIN + 300;
  typedef struct {logic [7:0] ctrl; logic [7:0] pat; int len;} ibcgd_txrow_type;
  typedef struct {
    logic [7:0] ctrl, up, dn, fpat;
    logic [3:0] flen;
    logic frm, err, eup, edn;
  } ibcgd_rxrow_type;
  ibcgd_txrow_type tx_rows [4] = '{'{8'h00, 8'h8F, 5}, '{8'h40, 8'hB4, 6},
    '{8'h80, 8'hCA, 7}, '{8'hC0, 8'h96, 8}};
  ibcgd_rxrow_type rx_rows [7] = '{
    '{8'h24, 8'h87, 8'hE0, 8'h80, 4'h5, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h24, 8'h87, 8'hE0, 8'hE0, 4'h5, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'h00, 8'h80, 8'h00, 8'hFF, 4'h1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{8'h3F, 8'h96, 8'h0F, 8'h96, 4'h8, 1'b0, 1'b1, 1'b1, 1'b0},
    '{8'h11, 8'hA0, 8'h40, 8'hA0, 4'h3, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h1E, 8'h10, 8'hFE, 8'hFE, 4'h7, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'h28, 8'h84, 8'h00, 8'h84, 4'h6, 1'b1, 1'b1, 1'b1, 1'b0}};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic tx_bit_req, tx_fbit_slot, tx_data_out, tx_code_active;
  logic tx_fbit_insert_en = 1'b0, rx_bit_valid, rx_bit;
  logic loopup_detected_flag, loopdown_detected_flag, irq;
  logic tx_go = 1'b0, rx_on = 1'b0, rx_framed = 1'b0, rx_errs = 1'b0;
  logic [7:0] rx_pat = 8'h00;
  logic [3:0] rx_len = 4'h1;
  int fail_count = 0, samples_checked = 0;
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  ibcgd_top #(.INTEG_CYCLES(WIN)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tx_bit_req(tx_bit_req), .tx_fbit_slot(tx_fbit_slot),
    .tx_fbit_value(1'b1), .tx_fbit_insert_en(tx_fbit_insert_en),
    .tx_data_in(1'b1), .tx_data_out(tx_data_out),
    .tx_code_active(tx_code_active), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit), .loopup_detected_flag(loopup_detected_flag),
    .loopdown_detected_flag(loopdown_detected_flag), .irq(irq));
  ibcgd_far_end far (.aclk(aclk), .aresetn(aresetn), .tx_go(tx_go),
    .rx_on(rx_on), .rx_framed(rx_framed), .rx_errs(rx_errs),
    .rx_pat(rx_pat), .rx_len(rx_len), .tx_bit_req(tx_bit_req),
    .tx_fbit_slot(tx_fbit_slot), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  // Trailing idle edge so no strobe is assigned twice in one step
  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d,
                        output logic [1:0] r);
    logic a, w, t;
    a = 1'b0;
    w = 1'b0;
    t = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!t) begin
      @(posedge aclk);
      if (bvalid) begin
        t = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask : axi_wr
  task automatic rd_chk(input string nm, input logic [5:0] idx,
                        input logic [7:0] e, input logic [1:0] er);
    logic t;
    t = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(posedge aclk);
      if (arready) begin
        t = 1'b1;
        arvalid <= 1'b0;
      end
    end
    t = 1'b0;
    while (!t) begin
      @(posedge aclk);
      if (rvalid) begin
        t = 1'b1;
        chk(nm, {24'h0, e}, rdata);
        chk("read response", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask : rd_chk
  // Line bit appears the cycle after its slot request
  task automatic get_bit(output logic b);
    @(posedge aclk);
    while (tx_bit_req !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    b = tx_data_out;
  endtask : get_bit
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
  initial begin
    int j, first, ones;
    logic b;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (tx_rows[i]) begin
      tx_go <= 1'b0;
      axi_wr(IDX_LEN_CTRL, tx_rows[i].ctrl, r);
      axi_wr(IDX_TX_PAT, tx_rows[i].pat, r);
      axi_wr(IDX_CTRL3, 8'h02, r);
      tx_go <= 1'b1;
      for (j = 0; j < 16; j++) begin
        get_bit(b);
        chk("tx bit", {31'h0, tx_rows[i].pat[7 - j % tx_rows[i].len]}, {31'h0, b});
      end
      chk("tx active", 32'h1, {31'h0, tx_code_active});
      axi_wr(IDX_CTRL3, 8'h00, r);
      get_bit(b);
      chk("tx idle bit", 32'h1, {31'h0, b});
      chk("tx inactive", 32'h0, {31'h0, tx_code_active});
    end
    axi_wr(IDX_TX_PAT, 8'h00, r);
    axi_wr(IDX_CTRL3, 8'h02, r);
    tx_fbit_insert_en <= 1'b1;
    first = 0;
    ones = 0;
    for (j = 0; j < 400; j++) begin
      get_bit(b);
      if (b === 1'b1) begin
        if (ones == 1) chk("F spacing", 32'd193, j - first);
        first = j;
        ones++;
      end
    end
    chk("F seen", 32'h1, {31'h0, ones >= 2});
    tx_fbit_insert_en <= 1'b0;
    ones = 0;
    for (j = 0; j < 200; j++) begin
      get_bit(b);
      ones += b;
    end
    chk("F suppressed", 32'h0, ones);
    foreach (rx_rows[i]) begin
      rx_pat <= rx_rows[i].fpat;
      rx_len <= rx_rows[i].flen;
      rx_framed <= rx_rows[i].frm;
      rx_errs <= rx_rows[i].err;
      rx_on <= 1'b1;
      axi_wr(IDX_LEN_CTRL, rx_rows[i].ctrl, r);
      axi_wr(IDX_RX_UP_PAT, rx_rows[i].up, r);
      axi_wr(IDX_RX_DN_PAT, rx_rows[i].dn, r);
      repeat (SETTLE) @(posedge aclk);
      chk("up flag", {31'h0, rx_rows[i].eup}, {31'h0, loopup_detected_flag});
      chk("down flag", {31'h0, rx_rows[i].edn}, {31'h0, loopdown_detected_flag});
      rd_chk("status", IDX_STATUS1, {rx_rows[i].eup, rx_rows[i].edn, 6'h00}, RESP_OKAY);
    end
    axi_wr(IDX_INT_STAT, 8'hFF, r);
    rx_on <= 1'b0;
    repeat (SETTLE) @(posedge aclk);
    chk("up flag lost", 32'h0, {31'h0, loopup_detected_flag});
    axi_wr(IDX_INT_MASK, 8'hC0, r);
    rx_on <= 1'b1;
    for (j = 0; j < 3; j++) begin
      // Flag cannot rise within 3/4 window of code; sure after two windows
      repeat ((j == 0) ? WIN / 2 : (j == 1) ? WIN + WIN / 2 + 200 : WIN)
        @(posedge aclk);
      rd_chk("polled status", IDX_STATUS1, (j == 0) ? 8'h00 : 8'h80, RESP_OKAY);
    end
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_chk("int status", IDX_INT_STAT, 8'h80, RESP_OKAY);
    axi_wr(IDX_INT_MASK, 8'h00, r);
    chk("irq masked", 32'h0, {31'h0, irq});
    axi_wr(IDX_INT_MASK, 8'h80, r);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    axi_wr(IDX_INT_STAT, 8'h80, r);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("int cleared", IDX_INT_STAT, 8'h00, RESP_OKAY);
    rx_on <= 1'b0;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("flags after reset", 32'h0, {30'h0, loopup_detected_flag, loopdown_detected_flag});
    for (j = 0; j < 8; j++) rd_chk("reset value", 6'(IDX_LEN_CTRL + j), 8'h00, RESP_OKAY);
    rd_chk("unmapped read", 6'h00, 8'h00, RESP_SLVERR);
    axi_wr(6'h3F, 8'hFF, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(IDX_LEN_CTRL, 8'hFF, r);
    rd_chk("length readback", IDX_LEN_CTRL, 8'hFF, RESP_OKAY);
    axi_wr(IDX_CTRL3, 8'hFF, r);
    rd_chk("control readback", IDX_CTRL3, 8'h02, RESP_OKAY);
    axi_wr(IDX_STATUS1, 8'hFF, r);
    rd_chk("status read only", IDX_STATUS1, 8'h00, RESP_OKAY);
    complete_run();
  end
endmodule : test_ibcgd_top
